/* File: hw/dmx_regs.svh */
// Register addresses, field positions and reset values of the DMA unit.
// Assumes the including file sits on the 8-bit special-function bus.
`ifndef DMX_REGS_SVH
`define DMX_REGS_SVH

// ----------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------
`define DMX_NCH        7
`define DMX_CHW        3

// ----------------------------------------------------------------------
// Special-function addresses
// ----------------------------------------------------------------------
`define DMX_A_INT      8'hD3
`define DMX_A_SEL      8'hC1
`define DMX_A_EN       8'hC2
`define DMX_A_BUSY     8'hC3
`define DMX_A_MINT     8'hC4
`define DMX_A_CF       8'hC5
`define DMX_A_MD       8'hC6
`define DMX_A_SZL      8'hC7
`define DMX_A_SZH      8'hC8
`define DMX_A_BAL      8'hC9
`define DMX_A_BAH      8'hCA
`define DMX_A_AOL      8'hCB
`define DMX_A_AOH      8'hCC
`define DMX_A_PADR     8'hCD

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DMX_CF_FULLIE  7
`define DMX_CF_MIDIE   6
`define DMX_CF_WIDE    1
`define DMX_CF_DIR     0
`define DMX_MD_WRAP    0
`define DMX_INT_UNUSED 7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DMX_RST_BYTE   8'h00
`define DMX_RST_WORD   16'h0000

`endif

/* File: hw/dmx_pkg.sv */
// Types shared by the DMA unit: engine states and the state record.
// Assumes dmx_regs.svh is on the include path.
`include "dmx_regs.svh"

package dmx_pkg;

  // --------------------------------------------------------------------
  // Engine states
  // --------------------------------------------------------------------
  typedef enum logic {
    DMX_IDLE,
    DMX_XFER
  } dmx_state_t;

  // --------------------------------------------------------------------
  // Whole state of the unit, registered as one record
  // --------------------------------------------------------------------
  typedef struct packed {
    dmx_state_t                            st;        // Engine state
    logic [`DMX_CHW-1:0]                   sel;       // Channel select
    logic [`DMX_CHW-1:0]                   act;       // Granted channel
    logic [1:0]                            left;      // Bytes left in txn
    logic [`DMX_NCH-1:0]                   en;        // Channel enables
    logic [`DMX_NCH-1:0]                   frc;       // Software-forced
    logic [`DMX_NCH-1:0]                   full;      // Full-length flags
    logic [`DMX_NCH-1:0]                   mid;       // Mid-point flags
    logic [`DMX_NCH-1:0][7:0]              cf;        // Config per channel
    logic [`DMX_NCH-1:0][7:0]              md;        // Mode per channel
    logic [`DMX_NCH-1:0][7:0]              padr;      // Peripheral address
    logic [`DMX_NCH-1:0][15:0]             size;      // Transfer size
    logic [`DMX_NCH-1:0][15:0]             base;      // Base address
    logic [`DMX_NCH-1:0][15:0]             offs;      // Address offset
    logic                                  pend;      // RAM byte in flight
    logic                                  held;      // Byte parked
    logic [7:0]                            hold;      // Parked byte
    logic [7:0]                            pend_adr;  // Its target address
  } dmx_state_rec_t;

endpackage : dmx_pkg

/* File: hw/dmx_prio_arb.sv */
// Fixed-priority picker: lowest-numbered active request wins.
// Assumes requests are already qualified by the caller.
`timescale 1ns/100ps

module dmx_prio_arb
#(
  parameter int N = 7,
  parameter int W = 3
)
(
  input  logic [N-1:0] req,
  output logic         gnt_valid,
  output logic [W-1:0] gnt_idx
);

  // --------------------------------------------------------------------
  // Priority scan
  // --------------------------------------------------------------------
  // Scan downwards so the lowest index overwrites all others
  always_comb
  begin
    gnt_valid = 1'b0;
    gnt_idx   = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        gnt_valid = 1'b1;
        gnt_idx   = W'(i);
      end
    end
  end

endmodule : dmx_prio_arb

/* File: hw/dmx_unit.sv */
// Multi-channel DMA unit moving bytes between the special-function bus
// and the on-chip data RAM, paced by peripheral requests.
// Assumes RAM read data arrives the cycle after a read strobe and that
// special-function reads return data in the same cycle.
//
// Behaviour
// - Full-length flag when offset reaches size
// - Mid-point flag at half size, rounded up
// - Copies either way, steered by channel configuration
// - RAM read, then register write; pipelined
// - Register-to-RAM byte takes one cycle
// - Busy bit shown while channel transfers
// - Size, base, offset writes ignored when busy
// - Setting busy bit forces a transfer
// - Offset counts zero to size-1, then completes
// - Wrap mode resets offset, keeps going
// - CPU bus activity stalls the engine
// - One grant, channel zero highest priority
// - Arbitrate at transaction boundaries; wide every two
// - Engine stops in sleep and suspend
// - Sleep waits for pending requests to finish
// - Wake-up interrupts served in channel priority
// - Engine halts while CPU is in debug
// - Flag register bits 6:0, bit 7 zero
// - Flags stay set until software clears
// - Config bit 7 enables full-length interrupt
`timescale 1ns/100ps
`include "dmx_regs.svh"

module dmx_unit
(
  input  logic                CLOCK,
  input  logic                RST_N,
  input  logic [7:0]          SFR_ADDR,
  input  logic                SFR_WR,
  input  logic [7:0]          SFR_WDATA,
  output logic [7:0]          SFR_RDATA,
  input  logic [`DMX_NCH-1:0] PERIPH_REQ,
  input  logic                CPU_BUS_BUSY,
  input  logic                DEBUG_HALT,
  input  logic                SLEEP_ACTIVE,
  output logic                SLEEP_READY,
  output logic [15:0]         ONCHIP_DATA_RAM_ADDR,
  output logic                ONCHIP_DATA_RAM_RD,
  output logic                ONCHIP_DATA_RAM_WR,
  output logic [7:0]          ONCHIP_DATA_RAM_WDATA,
  input  logic [7:0]          ONCHIP_DATA_RAM_RDATA,
  output logic [7:0]          DSFR_ADDR,
  output logic                DSFR_RD,
  output logic                DSFR_WR,
  output logic [7:0]          DSFR_WDATA,
  input  logic [7:0]          DSFR_RDATA,
  output logic                DMA_INT,
  output logic [`DMX_CHW-1:0] INT_CHAN
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  dmx_pkg::dmx_state_rec_t r;          // Registered state
  dmx_pkg::dmx_state_rec_t next_r;     // Next state
  logic [`DMX_NCH-1:0]     elig;       // Channels ready to move
  logic [`DMX_NCH-1:0]     ipend;      // Enabled pending flags
  logic [`DMX_NCH-1:0]     busy_vec;   // Busy bits as software sees
  logic                    gnt_v;      // Some channel may be granted
  logic [`DMX_CHW-1:0]     gnt_idx;    // Winning channel
  logic                    stall;      // Shared bus not available
  logic                    step;       // Engine moves a byte now
  logic                    at_end;     // This byte ends the size
  logic                    int_v;      // Valid of int picker, drives DMA_INT
  logic [`DMX_NCH-1:0]     full_set;   // Hardware sets this cycle
  logic [`DMX_NCH-1:0]     mid_set;    // Hardware sets this cycle
  logic [15:0]             nofs;       // Offset after this byte
  logic [`DMX_CHW-1:0]     c;          // Shorthand for granted channel
  logic [`DMX_CHW-1:0]     s;          // Shorthand for selected channel

  // Mid-point offset: half for even sizes, half plus one for odd
  function automatic logic [15:0] dmx_mid(input logic [15:0] sz);
    logic [16:0] t;
    t = {1'b0, sz} + 17'h00001;
    return t[16:1];
  endfunction : dmx_mid

  // --------------------------------------------------------------------
  // Qualification of channels and interrupt sources
  // --------------------------------------------------------------------
  // A raised flag parks the channel until software clears it
  always_comb
  begin
    for (int i = 0; i < `DMX_NCH; i++)
    begin
      elig[i]  = r.en[i] & ~r.full[i] & ~r.mid[i]
               & (PERIPH_REQ[i] | r.frc[i]);
      ipend[i] = (r.full[i] & r.cf[i][`DMX_CF_FULLIE])
               | (r.mid[i] & r.cf[i][`DMX_CF_MIDIE]);
      busy_vec[i] = r.frc[i]
                  | (r.st == dmx_pkg::DMX_XFER && r.act == `DMX_CHW'(i));
    end
  end

  // --------------------------------------------------------------------
  // Channel and interrupt pickers
  // --------------------------------------------------------------------
  // fixed priority grant
  dmx_prio_arb #(.N(`DMX_NCH), .W(`DMX_CHW)) u_chan_arb
  (
    .req       (elig),
    .gnt_valid (gnt_v),
    .gnt_idx   (gnt_idx)
  );

  dmx_prio_arb #(.N(`DMX_NCH), .W(`DMX_CHW)) u_int_arb
  (
    .req       (ipend),
    .gnt_valid (int_v),
    .gnt_idx   (INT_CHAN)
  );

  assign DMA_INT = int_v;

  // --------------------------------------------------------------------
  // Next-state and bus logic
  // --------------------------------------------------------------------
  always_comb
  begin
    next_r     = r;
    c          = r.act;
    s          = r.sel;
    full_set   = '0;
    mid_set    = '0;
    at_end     = 1'b0;
    nofs       = 16'(r.offs[c] + 16'h0001);
    ONCHIP_DATA_RAM_ADDR  = 16'(r.base[c] + r.offs[c]);
    ONCHIP_DATA_RAM_RD    = 1'b0;
    ONCHIP_DATA_RAM_WR    = 1'b0;
    ONCHIP_DATA_RAM_WDATA = DSFR_RDATA;
    DSFR_ADDR  = r.padr[c];
    DSFR_RD    = 1'b0;
    DSFR_WR    = 1'b0;
    DSFR_WDATA = r.held ? r.hold : ONCHIP_DATA_RAM_RDATA;
    // no activity in sleep or suspend
    stall = CPU_BUS_BUSY | DEBUG_HALT | SLEEP_ACTIVE;
    // Register-to-RAM needs the register bus the pending write holds
    step = (r.st == dmx_pkg::DMX_XFER) & ~stall
         & ~(r.pend & r.cf[c][`DMX_CF_DIR]);
    // sleep only once nothing is pending
    SLEEP_READY = (r.st == dmx_pkg::DMX_IDLE) & ~r.pend & ~(|elig);

    // Second stage of a RAM-to-register copy
    if (r.pend)
    begin
      if (!stall)
      begin
        DSFR_WR     = 1'b1;
        DSFR_ADDR   = r.pend_adr;
        next_r.pend = 1'b0;
        next_r.held = 1'b0;
      end
      else if (!r.held)
      begin
        // Bus taken: park the byte, RAM data is gone next cycle
        next_r.hold = ONCHIP_DATA_RAM_RDATA;
        next_r.held = 1'b1;
      end
    end

    unique case (r.st)
      dmx_pkg::DMX_IDLE:
      begin
        if (!stall && gnt_v)
        begin
          next_r.st   = dmx_pkg::DMX_XFER;
          next_r.act  = gnt_idx;
          next_r.left = r.cf[gnt_idx][`DMX_CF_WIDE] ? 2'd2 : 2'd1;
        end
      end
      dmx_pkg::DMX_XFER:
      begin
        if (step)
        begin
          if (r.cf[c][`DMX_CF_DIR])
          begin
            DSFR_RD = 1'b1;
            ONCHIP_DATA_RAM_WR = 1'b1;
          end
          else
          begin
            ONCHIP_DATA_RAM_RD         = 1'b1;
            next_r.pend     = 1'b1;
            next_r.held     = 1'b0;
            next_r.pend_adr = r.padr[c];
          end
          // last offset is size minus one
          at_end = (nofs == r.size[c]);
          if (nofs == dmx_mid(r.size[c]))
            mid_set[c] = 1'b1;
          if (at_end)
          begin
            next_r.frc[c] = 1'b0;
            if (r.md[c][`DMX_MD_WRAP])
              nofs = 16'h0000;
            else
              full_set[c] = 1'b1;
          end
          next_r.offs[c] = nofs;
          if (r.left == 2'd1 || full_set[c] || mid_set[c])
            next_r.st = dmx_pkg::DMX_IDLE;
          else
            next_r.left = r.left - 2'd1;
        end
      end
    endcase

    // Software writes; locked fields skip while the channel is busy
    if (SFR_WR)
    begin
      case (SFR_ADDR)
        `DMX_A_SEL:
          if (SFR_WDATA[`DMX_CHW-1:0] < `DMX_CHW'(`DMX_NCH))
            next_r.sel = SFR_WDATA[`DMX_CHW-1:0];
        `DMX_A_EN:   next_r.en = SFR_WDATA[`DMX_NCH-1:0];
        `DMX_A_BUSY: next_r.frc = next_r.frc | SFR_WDATA[`DMX_NCH-1:0];
        `DMX_A_CF:   next_r.cf[s] = SFR_WDATA;
        `DMX_A_MD:   next_r.md[s] = SFR_WDATA;
        `DMX_A_PADR: next_r.padr[s] = SFR_WDATA;
        default:
        begin
          if (!busy_vec[s])
          begin
            if (SFR_ADDR == `DMX_A_SZL) next_r.size[s][7:0]  = SFR_WDATA;
            if (SFR_ADDR == `DMX_A_SZH) next_r.size[s][15:8] = SFR_WDATA;
            if (SFR_ADDR == `DMX_A_BAL) next_r.base[s][7:0]  = SFR_WDATA;
            if (SFR_ADDR == `DMX_A_BAH) next_r.base[s][15:8] = SFR_WDATA;
            if (SFR_ADDR == `DMX_A_AOL) next_r.offs[s][7:0]  = SFR_WDATA;
            if (SFR_ADDR == `DMX_A_AOH) next_r.offs[s][15:8] = SFR_WDATA;
          end
        end
      endcase
    end

    // only software clears; hardware set wins
    next_r.full = ((SFR_WR && SFR_ADDR == `DMX_A_INT) ?
                   (r.full & SFR_WDATA[`DMX_NCH-1:0]) : r.full) | full_set;
    next_r.mid  = ((SFR_WR && SFR_ADDR == `DMX_A_MINT) ?
                   (r.mid & SFR_WDATA[`DMX_NCH-1:0]) : r.mid) | mid_set;

    // Read multiplexer; unmapped addresses read zero
    case (SFR_ADDR)
      `DMX_A_INT:  SFR_RDATA = {1'b0, r.full};
      `DMX_A_MINT: SFR_RDATA = {1'b0, r.mid};
      `DMX_A_SEL:  SFR_RDATA = {5'h00, r.sel};
      `DMX_A_EN:   SFR_RDATA = {1'b0, r.en};
      `DMX_A_BUSY: SFR_RDATA = {1'b0, busy_vec};
      `DMX_A_CF:   SFR_RDATA = r.cf[s];
      `DMX_A_MD:   SFR_RDATA = r.md[s];
      `DMX_A_PADR: SFR_RDATA = r.padr[s];
      `DMX_A_SZL:  SFR_RDATA = r.size[s][7:0];
      `DMX_A_SZH:  SFR_RDATA = r.size[s][15:8];
      `DMX_A_BAL:  SFR_RDATA = r.base[s][7:0];
      `DMX_A_BAH:  SFR_RDATA = r.base[s][15:8];
      `DMX_A_AOL:  SFR_RDATA = r.offs[s][7:0];
      `DMX_A_AOH:  SFR_RDATA = r.offs[s][15:8];
      default:     SFR_RDATA = `DMX_RST_BYTE;
    endcase
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      r <= '0;
    else
      r <= next_r;
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking dmx_cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  sequence s_ram_read;
    ONCHIP_DATA_RAM_RD;
  endsequence

  sequence s_bus_free;
    !stall;
  endsequence

  sequence s_granted;
    (r.st == dmx_pkg::DMX_IDLE) && !stall && gnt_v;
  endsequence

  a_cpu_bus_first: assert property (
    stall |-> !ONCHIP_DATA_RAM_RD && !ONCHIP_DATA_RAM_WR && !DSFR_RD && !DSFR_WR)
    else $error("engine used the bus while stalled");

  a_pipe_sfr_write: assert property (
    s_ram_read ##1 s_bus_free |-> DSFR_WR)
    else $error("register write missed the second cycle");

  a_one_cycle_copy: assert property (
    DSFR_RD |-> ONCHIP_DATA_RAM_WR && ONCHIP_DATA_RAM_WDATA == DSFR_RDATA)
    else $error("register-to-RAM byte not done in one cycle");

  a_busy_shown: assert property (
    (r.st == dmx_pkg::DMX_XFER) |-> busy_vec[r.act])
    else $error("active channel not shown busy");

  a_size_locked: assert property (
    SFR_WR && SFR_ADDR == `DMX_A_SZL && busy_vec[r.sel] |=> $stable(r.size))
    else $error("size written while busy");

  a_flag_holdoff: assert property (
    s_granted |=> !r.full[r.act] && !r.mid[r.act])
    else $error("channel granted with a flag set");

  a_fixed_prio: assert property (
    s_granted |-> elig[gnt_idx]
      && ((elig & ((`DMX_NCH'(1) << gnt_idx) - `DMX_NCH'(1))) == '0))
    else $error("lower-priority channel granted");

  a_flag_sticky: assert property (
    !(SFR_WR && SFR_ADDR == `DMX_A_INT) |=> (r.full & $past(r.full))
      == $past(r.full))
    else $error("full-length flag cleared without a write");

  a_full_at_size: assert property (
    step && at_end && !r.md[r.act][`DMX_MD_WRAP] |=> r.full[r.act])
    else $error("full-length flag missing at end of size");

  a_bit7_zero: assert property (
    SFR_ADDR == `DMX_A_INT |-> SFR_RDATA[`DMX_INT_UNUSED] == 1'b0)
    else $error("unused flag bit read as one");

  a_sleep_gate: assert property (
    SLEEP_READY |-> r.st == dmx_pkg::DMX_IDLE && !r.pend && elig == '0)
    else $error("sleep allowed with work pending");

endmodule : dmx_unit

/* File: test/dmx_far_model.sv */
// Far side of the DMA unit: data RAM and one peripheral register file.
// Assumes strobes from the unit are one-cycle pulses on rising edges.
`timescale 1ns/100ps

module dmx_far_model
(
  input  wire logic        clock,
  input  wire logic [15:0] onchip_data_ram_addr,
  input  wire logic        onchip_data_ram_rd,
  input  wire logic        onchip_data_ram_wr,
  input  wire logic [7:0]  onchip_data_ram_wdata,
  output logic      [7:0]  onchip_data_ram_rdata,
  input  wire logic [7:0]  dsfr_addr,
  input  wire logic        dsfr_rd,
  input  wire logic        dsfr_wr,
  input  wire logic [7:0]  dsfr_wdata,
  output logic      [7:0]  dsfr_rdata
);
  logic [7:0]  ram [0:255];  // RAM image, low address byte only
  logic [7:0]  preg [0:255]; // Peripheral registers
  logic [7:0]  sfr_log [$];  // Bytes written into peripheral registers
  logic [15:0] wr_adr [$];   // RAM write addresses, in order
  logic [7:0]  idle_pat;     // Changes every cycle when nothing valid

  initial
  begin
    idle_pat   = 8'hA5;
    onchip_data_ram_rdata = 8'h3C;
  end

  // Read data one cycle late; otherwise garbage so stale bytes never pass
  always @(posedge clock)
  begin
    idle_pat <= ~idle_pat;
    if (onchip_data_ram_rd)
      onchip_data_ram_rdata <= ram[onchip_data_ram_addr[7:0]];
    else
      onchip_data_ram_rdata <= ~onchip_data_ram_rdata;
    if (onchip_data_ram_wr)
    begin
      ram[onchip_data_ram_addr[7:0]] <= onchip_data_ram_wdata;
      wr_adr.push_back(onchip_data_ram_addr);
    end
    if (dsfr_wr)
    begin
      preg[dsfr_addr] <= dsfr_wdata;
      sfr_log.push_back(dsfr_wdata);
    end
  end

  // Register read answers in the same cycle only while strobed
  assign dsfr_rdata = dsfr_rd ? preg[dsfr_addr] : idle_pat;
endmodule : dmx_far_model

/* File: test/multichannel_sfr_onchip_data_ram_dma_tb.sv */
// Self-checking bench for the DMA unit with a RAM/peripheral model.
// Assumes dmx_regs.svh on the include path; inputs move on falling edges.
`timescale 1ns/100ps
`include "dmx_regs.svh"

module multichannel_sfr_onchip_data_ram_dma_tb;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  logic        sfr_wr = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [7:0]  sfr_rdata;
  logic [6:0]  periph_req = 7'h00;
  logic        cpu_busy = 1'b0;
  logic        dbg = 1'b0;
  logic        slp = 1'b0;
  logic        sleep_ready, dma_int;
  logic [2:0]  int_chan;
  logic [15:0] xa;
  logic        xrd, xwr, srd, swr;
  logic [7:0]  xwd, xrdat, sa, swd, srdat, d;
  logic [7:0]  exp_q [$]; // Bytes expected at the peripheral
  int          err_count = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          size, i, n0;

  always #25 clock = ~clock;

  dmx_unit dut (.CLOCK(clock), .RST_N(rst_n), .SFR_ADDR(sfr_addr),
    .SFR_WR(sfr_wr), .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata),
    .PERIPH_REQ(periph_req), .CPU_BUS_BUSY(cpu_busy), .DEBUG_HALT(dbg),
    .SLEEP_ACTIVE(slp), .SLEEP_READY(sleep_ready), .ONCHIP_DATA_RAM_ADDR(xa),
    .ONCHIP_DATA_RAM_RD(xrd), .ONCHIP_DATA_RAM_WR(xwr), .ONCHIP_DATA_RAM_WDATA(xwd), .ONCHIP_DATA_RAM_RDATA(xrdat),
    .DSFR_ADDR(sa), .DSFR_RD(srd), .DSFR_WR(swr), .DSFR_WDATA(swd),
    .DSFR_RDATA(srdat), .DMA_INT(dma_int), .INT_CHAN(int_chan));

  dmx_far_model far (.clock(clock), .onchip_data_ram_addr(xa), .onchip_data_ram_rd(xrd),
    .onchip_data_ram_wr(xwr), .onchip_data_ram_wdata(xwd), .onchip_data_ram_rdata(xrdat), .dsfr_addr(sa),
    .dsfr_rd(srd), .dsfr_wr(swr), .dsfr_wdata(swd), .dsfr_rdata(srdat));

  // Verdict and end of run, also reached by the cycle ceiling
  task final_report;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask : chk

  // One-cycle register write pulse
  task sw(input logic [7:0] a, input logic [7:0] v);
    @(negedge clock);
    sfr_addr  = a;
    sfr_wdata = v;
    sfr_wr    = 1'b1;
    @(negedge clock);
    sfr_wr = 1'b0;
  endtask : sw

  // Combinational read, sampled once settled
  task sr(input logic [7:0] a, output logic [7:0] v);
    @(negedge clock);
    sfr_addr = a;
    #5 v = sfr_rdata;
  endtask : sr

  // Poll until all mask bits set; the CPU randomly steals the bus meanwhile
  task wait_bits(input logic [7:0] a, input logic [7:0] m);
    int n;
    n = 0;
    d = 8'h00;
    while (((d & m) !== m) && n < 400)
    begin
      sr(a, d);
      cpu_busy = ($urandom % 4) == 0;
      n++;
    end
    cpu_busy = 1'b0;
    chk(16'(n < 400), 16'h0001);
  endtask : wait_bits

  task cfg(input logic [7:0] ch, input logic [15:0] b, input logic [7:0] s,
           input logic [7:0] pa, input logic [7:0] cf);
    sw(`DMX_A_SEL, ch);
    sw(`DMX_A_BAL, b[7:0]);
    sw(`DMX_A_BAH, b[15:8]);
    sw(`DMX_A_SZL, s);
    sw(`DMX_A_SZH, 8'h00);
    sw(`DMX_A_AOL, 8'h00);
    sw(`DMX_A_AOH, 8'h00);
    sw(`DMX_A_PADR, pa);
    sw(`DMX_A_CF, cf);
    sw(`DMX_A_MD, 8'h00);
  endtask : cfg

  // Hang guard at 20000 cycles, far above the expected run of a few hundred
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      final_report();
    end
  end

  initial
  begin
    void'($urandom(32'h1F15));
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    // Reset values and an unmapped read
    sr(`DMX_A_INT, d);
    chk(d, 8'h00);
    sr(8'hE0, d);
    chk(d, 8'h00);
    chk(sleep_ready, 1'b1);
    // RAM to register, paced by requests, random length
    size = 3 + $urandom % 6;
    for (i = 0; i < size; i++)
    begin
      far.ram[8'h40 + i] = 8'($urandom);
      exp_q.push_back(far.ram[8'h40 + i]);
    end
    cfg(8'h02, 16'h0040, 8'(size), 8'h11, 8'h80);
    sw(`DMX_A_EN, 8'h04);
    periph_req[2] = 1'b1;
    wait_bits(`DMX_A_MINT, 8'h04);
    repeat (6) @(negedge clock);
    chk(16'(far.sfr_log.size()), 16'((size + 1) >> 1));
    chk(dma_int, 1'b0);
    sw(`DMX_A_MINT, 8'hFB);
    wait_bits(`DMX_A_INT, 8'h04);
    repeat (10) @(negedge clock);
    chk(16'(far.sfr_log.size()), 16'(size));
    for (i = 0; i < size; i++)
      chk(far.sfr_log[i], exp_q[i]);
    chk(far.preg[8'h11], exp_q[size - 1]);
    chk({dma_int, int_chan}, 4'hA);
    periph_req = 7'h00;
    sw(`DMX_A_INT, 8'hFF);
    sr(`DMX_A_INT, d);
    chk(d, 8'h04);
    sw(`DMX_A_INT, 8'h80);
    sr(`DMX_A_INT, d);
    chk(d, 8'h00);
    // Register to RAM, forced by software, held by debug first
    far.preg[8'h21] = 8'($urandom);
    cfg(8'h01, 16'h0080, 8'h03, 8'h21, 8'h01);
    sw(`DMX_A_EN, 8'h02);
    dbg = 1'b1;
    n0 = far.wr_adr.size();
    sw(`DMX_A_BUSY, 8'h02);
    sw(`DMX_A_SZL, 8'h09);
    sr(`DMX_A_SZL, d);
    chk(d, 8'h03);
    sr(`DMX_A_BUSY, d);
    chk(d, 8'h02);
    chk(sleep_ready, 1'b0);
    repeat (8) @(negedge clock);
    chk(16'(far.wr_adr.size()), 16'(n0));
    dbg = 1'b0;
    wait_bits(`DMX_A_MINT, 8'h02);
    sw(`DMX_A_MINT, 8'hFD);
    wait_bits(`DMX_A_INT, 8'h02);
    for (i = 0; i < 3; i++)
      chk(far.ram[8'h80 + i], far.preg[8'h21]);
    sr(`DMX_A_BUSY, d);
    chk(d, 8'h00);
    sw(`DMX_A_INT, 8'h00);
    // Two forced channels released together out of sleep
    cfg(8'h00, 16'h00A0, 8'h02, 8'h30, 8'h01);
    cfg(8'h03, 16'h00C0, 8'h02, 8'h31, 8'h01);
    sw(`DMX_A_EN, 8'h09);
    slp = 1'b1;
    n0 = far.wr_adr.size();
    sw(`DMX_A_BUSY, 8'h09);
    repeat (6) @(negedge clock);
    chk(16'(far.wr_adr.size()), 16'(n0));
    slp = 1'b0;
    wait_bits(`DMX_A_MINT, 8'h09);
    chk(far.wr_adr[n0], 16'h00A0);
    chk(far.wr_adr[n0 + 1], 16'h00C0);
    // Wide RAM-to-register copies; the offset wraps and keeps going
    exp_q.delete();
    for (i = 0; i < 4; i++)
      far.ram[8'h60 + i] = 8'($urandom);
    for (i = 0; i < 6; i++)
      exp_q.push_back(far.ram[8'h60 + (i % 4)]);
    cfg(8'h04, 16'h0060, 8'h04, 8'h40, 8'h42);
    sw(`DMX_A_MD, 8'h01);
    sw(`DMX_A_EN, 8'h10);
    n0 = far.sfr_log.size();
    periph_req[4] = 1'b1;
    wait_bits(`DMX_A_MINT, 8'h10);
    repeat (4) @(negedge clock);
    chk(16'(far.sfr_log.size() - n0), 16'h0002);
    chk({dma_int, int_chan}, 4'hC);
    sw(`DMX_A_MINT, 8'hEF);
    wait_bits(`DMX_A_MINT, 8'h10);
    repeat (4) @(negedge clock);
    periph_req = 7'h00;
    chk(16'(far.sfr_log.size() - n0), 16'h0006);
    for (i = 0; i < 6; i++)
      chk(far.sfr_log[n0 + i], exp_q[i]);
    sr(`DMX_A_INT, d);
    chk(d, 8'h00);
    sr(`DMX_A_AOL, d);
    chk(d, 8'h02);
    sr(`DMX_A_BUSY, d);
    chk(d, 8'h09);
    final_report();
  end
endmodule : multichannel_sfr_onchip_data_ram_dma_tb
